/* logic/periph_irq_regs.svh */
`ifndef PERIPH_IRQ_REGS_SVH
`define PERIPH_IRQ_REGS_SVH

// ------------------------------------------------------------
// Register offsets on the plain register port
// ------------------------------------------------------------
`define OFS_INTERRUPT_CONTROL 3'h0
`define OFS_ENABLE_ONE        3'h1
`define OFS_ENABLE_TWO        3'h2
`define OFS_REQUEST_ONE       3'h3
`define OFS_IRQ_STATUS        3'h4
`define OFS_IRQ_MASK          3'h5

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_GLOBAL_GATE       7
`define BIT_PERIPH_GATE       6
`define BIT_RX_FLAG           5
`define BIT_TX_FLAG           4
`define BIT_TIMER_TWO_MATCH   1
`define BIT_TIMER_ONE_OVF     0

// ------------------------------------------------------------
// Implemented-bit masks, request one read-only mask and reset value
// ------------------------------------------------------------
`define MASK_CONTROL          8'hC0
`define MASK_ENABLE_TWO       8'hF8
`define MASK_REQ_READ_ONLY    8'h30
`define RST_BYTE              8'h00

`endif

/* logic/periph_irq_pkg.sv */
`default_nettype none

package periph_irq_pkg;

    // State of the request flag bank
    typedef struct packed {
        logic [7:0] flags;
    } flag_state_t;

    // State of the top block
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] enableOne;
        logic [7:0] enableTwo;
        logic [7:0] flagsPrev;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdData;
        logic       periphReq;
        logic       irqOut;
    } top_state_t;

endpackage

`default_nettype wire

/* logic/irq_flag_bank.sv */
`include "periph_irq_regs.svh"
`default_nettype none

module irq_flag_bank
    import periph_irq_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] setEvt,
    input  wire logic [7:0] followLevel,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] flags
);

    flag_state_t st_q;
    flag_state_t st_d;

    // Next flags: writable bits take writes, events win over clears
    always_comb begin
        st_d = st_q;
        if (wrEn) begin
            st_d.flags = (st_q.flags & `MASK_REQ_READ_ONLY) | (wrData & ~`MASK_REQ_READ_ONLY);
        end
        st_d.flags = st_d.flags | (setEvt & ~`MASK_REQ_READ_ONLY); // R02
        // Receive and transmit follow their peripheral, software cannot write
        st_d.flags = (st_d.flags & ~`MASK_REQ_READ_ONLY) | (followLevel & `MASK_REQ_READ_ONLY); // R07
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0; // R08
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;

    a_set_wins: assert property (@(posedge mclk) disable iff (rst) // R02
        setEvt[`BIT_TIMER_ONE_OVF] && wrEn |=> flags[`BIT_TIMER_ONE_OVF])
        else $error("timer one overflow event lost against a write");

endmodule

`default_nettype wire

/* logic/periph_irq_ctrl.sv */
// What this block does
// [R01] No peripheral request without the peripheral gate
// [R02] Flags set on events regardless of enables
// [R03] Software clears a flag before enabling it
// [R04] Enable two: oscillator, comparators, eeprom, collision bits
// [R05] Enable two bits 2..0 read zero, ignore writes
// [R06] Request one holds eight peripheral pending flags
// [R07] Receive/transmit flags read-only, follow peripheral state
// [R08] All enables and flags reset to zero
// [R09] Enable one pairs bit for bit with flags
// [R10] Request when flag and enable, both gates set
//
// The address map and strobed register access were chosen for this implementation.
`include "periph_irq_regs.svh"
`default_nettype none

module periph_irq_ctrl
    import periph_irq_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    // Register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    output logic      [7:0] regRdData,
    // Peripheral event pulses, request one layout
    input  wire logic [7:0] flagSetEvt,
    // Receive buffer full and transmit buffer empty levels
    input  wire logic       serialRxReady,
    input  wire logic       serialTxReady,
    // Pending flags of the second request register, held outside
    input  wire logic [7:0] pendingTwo,
    // Request to the core and the block interrupt
    output logic            periphIrqReq,
    output logic            irqOut,
    // Enable bits for sources outside
    output logic      [7:0] enableOneOut,
    output logic      [7:0] enableTwoOut
);

    // ------------------------------------------------------------
    // Storage and wiring
    // ------------------------------------------------------------
    top_state_t st_q;
    top_state_t st_d;
    logic [7:0] flagsOne;
    logic [7:0] followLevel;
    logic       wrReqOne;

    // Address match for strobed accesses
    function automatic logic hit(input logic stb, input logic [2:0] a, input logic [2:0] ofs);
        hit = stb && (a == ofs);
    endfunction

    // Any enabled pending source
    function automatic logic anyPending(input logic [7:0] pend, input logic [7:0] en);
        anyPending = |(pend & en);
    endfunction

    // Peripheral state levels land on their flag positions
    always_comb begin
        followLevel                = 8'h00;
        followLevel[`BIT_RX_FLAG]  = serialRxReady;
        followLevel[`BIT_TX_FLAG]  = serialTxReady;
    end

    assign wrReqOne = hit(regWrStb, regAddr, `OFS_REQUEST_ONE);

    // ------------------------------------------------------------
    // Request flag bank
    // ------------------------------------------------------------
    irq_flag_bank u_flags (
        .mclk        (mclk),
        .rst         (rst),
        .setEvt      (flagSetEvt),
        .followLevel (followLevel),
        .wrEn        (wrReqOne),
        .wrData      (regWrData),
        .flags       (flagsOne)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // Gate bits of the interrupt control register
        if (hit(regWrStb, regAddr, `OFS_INTERRUPT_CONTROL)) begin
            st_d.control = regWrData & `MASK_CONTROL;
        end

        // Enable one, pairs with the request flags bit for bit
        if (hit(regWrStb, regAddr, `OFS_ENABLE_ONE)) begin
            st_d.enableOne = regWrData; // R09
        end

        // Enable two, low three bits unimplemented
        if (hit(regWrStb, regAddr, `OFS_ENABLE_TWO)) begin
            st_d.enableTwo = regWrData & `MASK_ENABLE_TWO; // R04 R05
        end

        // Mask of the block interrupt
        if (hit(regWrStb, regAddr, `OFS_IRQ_MASK)) begin
            st_d.mask = regWrData;
        end

        // Sticky status: a new pending flag sets, write one clears, set wins
        st_d.flagsPrev = flagsOne;
        if (hit(regWrStb, regAddr, `OFS_IRQ_STATUS)) begin
            st_d.status = st_q.status & ~regWrData;
        end
        st_d.status = st_d.status | (flagsOne & ~st_q.flagsPrev);

        // Read data stands only in the cycle after the strobe
        st_d.rdData = 8'h00;
        if (regRdStb) begin
            unique case (regAddr)
                `OFS_INTERRUPT_CONTROL: st_d.rdData = st_q.control;
                `OFS_ENABLE_ONE:        st_d.rdData = st_q.enableOne;
                `OFS_ENABLE_TWO:        st_d.rdData = st_q.enableTwo & `MASK_ENABLE_TWO; // R05
                `OFS_REQUEST_ONE:       st_d.rdData = flagsOne; // R06
                `OFS_IRQ_STATUS:        st_d.rdData = st_q.status;
                `OFS_IRQ_MASK:          st_d.rdData = st_q.mask;
                default:                st_d.rdData = 8'h00;
            endcase
        end

        // Core request through peripheral gate and global gate
        st_d.periphReq = st_q.control[`BIT_GLOBAL_GATE]
                       && st_q.control[`BIT_PERIPH_GATE] // R01
                       && (anyPending(flagsOne, st_q.enableOne)
                           || anyPending(pendingTwo, st_q.enableTwo)); // R10

        // Level interrupt while an unmasked status bit is set
        st_d.irqOut = |(st_q.status & st_q.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0; // R08
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign regRdData    = st_q.rdData;
    assign periphIrqReq = st_q.periphReq;
    assign irqOut       = st_q.irqOut;
    assign enableOneOut = st_q.enableOne;
    assign enableTwoOut = st_q.enableTwo;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_gate_blocks: assert property (@(posedge mclk) disable iff (rst) // R01
        !st_q.control[`BIT_PERIPH_GATE] |=> !periphIrqReq)
        else $error("peripheral request with peripheral gate clear");

    a_flag_sets: assert property (@(posedge mclk) disable iff (rst) // R02
        flagSetEvt[`BIT_TIMER_TWO_MATCH] && st_q.enableOne == 8'h00 |=> flagsOne[`BIT_TIMER_TWO_MATCH])
        else $error("flag not set while source disabled");

    a_en2_layout: assert property (@(posedge mclk) disable iff (rst) // R04
        hit(regWrStb, regAddr, `OFS_ENABLE_TWO) |=> enableTwoOut[7:3] == $past(regWrData[7:3]))
        else $error("enable two upper bits not stored");

    a_en2_low_zero: assert property (@(posedge mclk) disable iff (rst) // R05
        enableTwoOut[2:0] == 3'h0)
        else $error("enable two low bits not zero");

    a_read_flags: assert property (@(posedge mclk) disable iff (rst) // R06
        hit(regRdStb, regAddr, `OFS_REQUEST_ONE) |=> regRdData == $past(flagsOne))
        else $error("request one read mismatch");

    a_ro_follow: assert property (@(posedge mclk) disable iff (rst) // R07
        wrReqOne ##1 1'b1 |-> flagsOne[`BIT_RX_FLAG] == $past(serialRxReady)
                            && flagsOne[`BIT_TX_FLAG] == $past(serialTxReady))
        else $error("read-only flag altered by write");

    a_reset_zero: assert property (@(posedge mclk) // R08
        rst |=> enableOneOut == 8'h00 && enableTwoOut == 8'h00 && flagsOne == 8'h00)
        else $error("state not zero after reset");

    a_pair_bit: assert property (@(posedge mclk) disable iff (rst) // R09
        st_q.control[7:6] == 2'h3 && flagsOne[`BIT_TIMER_ONE_OVF] && st_q.enableOne[`BIT_TIMER_ONE_OVF]
        |=> periphIrqReq)
        else $error("enabled timer one overflow gave no request");

    a_req_cause: assert property (@(posedge mclk) disable iff (rst) // R10
        periphIrqReq |-> $past(st_q.control[`BIT_GLOBAL_GATE])
                      && ($past(anyPending(flagsOne, st_q.enableOne))
                          || $past(anyPending(pendingTwo, st_q.enableTwo))))
        else $error("request without enabled pending source");

    a_irq_level: assert property (@(posedge mclk) disable iff (rst)
        ##1 irqOut == $past(|(st_q.status & st_q.mask)))
        else $error("interrupt output does not follow status and mask");

    a_read_gap: assert property (@(posedge mclk) disable iff (rst)
        !regRdStb |=> regRdData == 8'h00)
        else $error("read data outside its cycle");

endmodule

`default_nettype wire

/* tb/periph_event_source.sv */
`default_nettype none

module periph_event_source (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] evtReq,
    input  wire logic       rxReq,
    input  wire logic       txReq,
    output logic      [7:0] flagSetEvt,
    output logic            serialRxReady,
    output logic            serialTxReady
);
    timeunit 1ns;
    timeprecision 1ps;

    // Events leave as one-cycle pulses, serial sources as levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            flagSetEvt    <= 8'h00;
            serialRxReady <= 1'b0;
            serialTxReady <= 1'b0;
        end else begin
            flagSetEvt    <= evtReq & 8'hCF;
            serialRxReady <= rxReq;
            serialTxReady <= txReq;
        end
    end
endmodule

`default_nettype wire

/* tb/test_periph_irq_ctrl.sv */
`include "periph_irq_regs.svh"
`default_nettype none

module test_periph_irq_ctrl
    import periph_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic       regWrStb = 1'b0;
    logic       regRdStb = 1'b0;
    logic [7:0] evtReq = 8'h00;
    logic       rxReq = 1'b0;
    logic       txReq = 1'b0;
    logic [7:0] pendingTwo = 8'h00;
    logic [7:0] regRdData, flagSetEvt, enableOneOut, enableTwoOut;
    logic       serialRxReady, serialTxReady, periphIrqReq, irqOut;
    logic [7:0] w, c, e, p;
    int         failures = 0;
    int         numChecks = 0;
    int         cycles = 0;
    integer     seed = 32'h2F1B;

    periph_irq_ctrl u_periph_irq_ctrl (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .flagSetEvt(flagSetEvt),
        .serialRxReady(serialRxReady), .serialTxReady(serialTxReady), .pendingTwo(pendingTwo),
        .periphIrqReq(periphIrqReq), .irqOut(irqOut), .enableOneOut(enableOneOut), .enableTwoOut(enableTwoOut));
    periph_event_source u_periph_event_source (.mclk(mclk), .rst(rst), .evtReq(evtReq), .rxReq(rxReq),
        .txReq(txReq), .flagSetEvt(flagSetEvt), .serialRxReady(serialRxReady), .serialTxReady(serialTxReady));

    // Clock and hang guard
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge mclk);
        evtReq <= v;
        @(posedge mclk);
        evtReq <= 8'h00;
    endtask

    task automatic regs_zero();
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 8'h00);
        end
        check(enableOneOut | enableTwoOut, 8'h00);
        check({6'h00, irqOut, periphIrqReq}, 8'h00);
    endtask

    // Expected request to the core
    function automatic logic req_exp(input logic [7:0] ctl, en1, fl, en2, p2);
        return ctl[7] & ctl[6] & (|(en1 & fl) | |(en2 & p2));
    endfunction

    task automatic complete_run();
        $display("checks=%0d failures=%0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        regs_zero();
        for (int b = 0; b < 8; b++) begin
            wr(`OFS_ENABLE_TWO, 8'h01 << b);
            rd(`OFS_ENABLE_TWO, (8'h01 << b) & 8'hF8);
        end
        wr(`OFS_ENABLE_TWO, 8'hFF);
        idle(0);
        check(enableTwoOut, 8'hF8);
        wr(`OFS_INTERRUPT_CONTROL, 8'hFF);
        rd(`OFS_INTERRUPT_CONTROL, 8'hC0);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            rxReq <= 1'($random(seed));
            txReq <= 1'($random(seed));
            w = 8'($random(seed));
            wr(`OFS_REQUEST_ONE, w);
            rd(`OFS_REQUEST_ONE, (w & 8'hCF) | {2'b00, rxReq, txReq, 4'h0});
        end
        @(posedge mclk);
        rxReq <= 1'b0;
        txReq <= 1'b0;
        wr(`OFS_INTERRUPT_CONTROL, 8'h00);
        wr(`OFS_ENABLE_ONE, 8'h00);
        wr(`OFS_REQUEST_ONE, 8'h00);
        pulse(8'h01);
        idle(5);
        rd(`OFS_REQUEST_ONE, 8'h01);
        for (int i = 0; i < 12; i++) begin
            c = (i < 4) ? {i[1:0], 6'h00} : 8'($random(seed));
            e = (i < 4) ? 8'h01 : 8'($random(seed));
            p = (i < 4) ? 8'h00 : 8'($random(seed));
            wr(`OFS_INTERRUPT_CONTROL, c);
            wr(`OFS_ENABLE_ONE, e);
            pendingTwo <= p;
            idle(3);
            check({7'h00, periphIrqReq}, {7'h00, req_exp(c, e, 8'h01, 8'hF8, p)});
            check(enableOneOut, e);
        end
        wr(`OFS_ENABLE_ONE, 8'h00);
        pendingTwo <= 8'h00;
        // Event and clearing write meet in one cycle: the event wins
        @(posedge mclk);
        evtReq <= 8'h01;
        @(posedge mclk);
        evtReq <= 8'h00;
        regAddr <= `OFS_REQUEST_ONE;
        regWrData <= 8'h00;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
        rd(`OFS_REQUEST_ONE, 8'h01);
        wr(`OFS_REQUEST_ONE, 8'h00);
        wr(`OFS_IRQ_STATUS, 8'hFF);
        wr(`OFS_IRQ_MASK, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h00);
        pulse(8'h01);
        idle(5);
        check({7'h00, irqOut}, 8'h01);
        rd(`OFS_IRQ_STATUS, 8'h01);
        wr(`OFS_IRQ_MASK, 8'h00);
        idle(2);
        check({7'h00, irqOut}, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h01);
        idle(2);
        check({7'h00, irqOut}, 8'h01);
        wr(`OFS_IRQ_STATUS, 8'h01);
        idle(2);
        check({7'h00, irqOut}, 8'h00);
        pulse(8'hFF);
        idle(2);
        rd(`OFS_REQUEST_ONE, 8'hCF);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        regs_zero();
        complete_run();
    end
endmodule

`default_nettype wire
